//--- design/sbs_defs.vh
// constants for the status byte and service request block
`ifndef SBS_DEFS_VH
`define SBS_DEFS_VH

// command codes on the command port
`define SBS_OP_NOP      4'h0
`define SBS_OP_STB_Q    4'h1
`define SBS_OP_SRE_W    4'h2
`define SBS_OP_SRE_Q    4'h3
`define SBS_OP_PRE_W    4'h4
`define SBS_OP_PRE_Q    4'h5
`define SBS_OP_ESE_W    4'h6
`define SBS_OP_ESE_Q    4'h7
`define SBS_OP_ESR_Q    4'h8
`define SBS_OP_IST_Q    4'h9
`define SBS_OP_OPC      4'hA
`define SBS_OP_CLS      4'hB

// status byte bit positions
`define SBS_STB_ERRQ    2
`define SBS_STB_QUES    3
`define SBS_STB_MAV     4
`define SBS_STB_ESB     5
`define SBS_STB_MSS     6
`define SBS_STB_OPER    7

// standard event flag bit positions
`define SBS_EV_OPC      0
`define SBS_EV_QYE      2
`define SBS_EV_DDE      3
`define SBS_EV_EXE      4
`define SBS_EV_CME      5
`define SBS_EV_URQ      6
`define SBS_EV_PON      7

// reset values, plus the unused-bit mask
`define SBS_SRE_RST     8'h00
`define SBS_PPE_RST     8'h00
`define SBS_ESE_RST     8'h00
`define SBS_ESR_RST     8'h80
`define SBS_UNUSED_MASK 8'hFC

// error code class bounds
`define SBS_CME_HI      (-100)
`define SBS_CME_LO      (-199)
`define SBS_EXE_HI      (-200)
`define SBS_EXE_LO      (-299)
`define SBS_DDE_HI      (-300)
`define SBS_DDE_LO      (-399)

`endif

//--- design/sbs_event_flags.v
// sticky standard event flags, cleared by reading
`timescale 1ns/1ns
module sbs_event_flags #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys_i,
  input  wire             arst_n_i,
  input  wire [WIDTH-1:0] set_i,
  input  wire             clear_i,
  output wire [WIDTH-1:0] flags_o
);
`include "sbs_defs.vh"

  reg  [WIDTH-1:0] flags_ff;
  wire [WIDTH-1:0] nxt_flags;

  // a flag set in the clearing cycle survives the clear
  assign nxt_flags = (clear_i ? {WIDTH{1'b0}} : flags_ff) | set_i;

  // power-on event comes from the reset value itself
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_ff <= `SBS_ESR_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags_o = flags_ff;

endmodule // sbs_event_flags

//--- design/sbs_status_byte.v
// status byte, service request, parallel poll and standard event logic
`timescale 1ns/1ns
module sbs_status_byte (
  input  wire              clk_sys_i,
  input  wire              arst_n_i,
  input  wire              cmd_valid_i,
  input  wire [3:0]        cmd_op_i,
  input  wire [7:0]        cmd_data_i,
  output wire              rsp_valid_o,
  output wire [7:0]        rsp_data_o,
  input  wire              spoll_i,
  output wire              spoll_valid_o,
  output wire [7:0]        spoll_data_o,
  output wire              ist_o,
  output wire              srq_o,
  input  wire              err_event_i,
  input  wire signed [15:0] err_code_i,
  output wire              err_enq_o,
  output wire [15:0]       err_code_o,
  input  wire              err_queue_nonempty_i,
  input  wire              ques_summary_i,
  input  wire              oper_summary_i,
  input  wire              mav_i,
  input  wire              all_done_i,
  input  wire              query_err_i,
  input  wire              local_i
);
`include "sbs_defs.vh"

  reg  [7:0]  sre_ff;
  reg  [7:0]  ppe_ff;
  reg  [7:0]  ese_ff;
  reg  [7:0]  req_prev_ff;
  reg         rqs_ff;
  reg         opc_pend_ff;
  reg         local_prev_ff;
  reg         ist_ff;
  reg         rsp_valid_ff;
  reg  [7:0]  rsp_data_ff;
  reg         spoll_valid_ff;
  reg  [7:0]  spoll_data_ff;
  reg         err_enq_ff;
  reg  [15:0] err_code_ff;

  reg  [7:0]  esr_set;
  reg  [7:0]  stb_low;
  wire [7:0]  standard_event_flags;
  wire        esr_clear;
  wire        esb;
  wire [7:0]  sre_eff;
  wire [7:0]  req_now;
  wire        mss;
  wire [7:0]  stb;
  wire        ist;
  wire        srq_event;
  wire        opc_done;
  wire        is_write;

  // true when a signed code lies inside an inclusive class range
  function in_range;
    input signed [15:0] code;
    input integer       lo;
    input integer       hi;
    begin
      in_range = (code >= lo) && (code <= hi);
    end
  endfunction

  // one strobed command of the given code
  function cmd_hit;
    input       valid;
    input [3:0] op;
    input [3:0] code;
    begin
      cmd_hit = valid && (op == code);
    end
  endfunction

  // maps an error code to the event flag its class sets
  function [7:0] err_class;
    input signed [15:0] code;
    begin
      err_class = 8'h00;
      if (in_range(code, `SBS_CME_LO, `SBS_CME_HI)) begin
        err_class[`SBS_EV_CME] = 1'b1;
      end else if (in_range(code, `SBS_EXE_LO, `SBS_EXE_HI)) begin
        err_class[`SBS_EV_EXE] = 1'b1;
      end else if (in_range(code, `SBS_DDE_LO, `SBS_DDE_HI) || code > 0) begin
        err_class[`SBS_EV_DDE] = 1'b1;
      end
    end
  endfunction

  // one-hot bit of a status byte position
  function [7:0] bit_at;
    input integer pos;
    begin
      bit_at = 8'h00;
      bit_at[pos] = 1'b1;
    end
  endfunction

  assign is_write  = cmd_hit(cmd_valid_i, cmd_op_i, `SBS_OP_SRE_W)
                   || cmd_hit(cmd_valid_i, cmd_op_i, `SBS_OP_PRE_W)
                   || cmd_hit(cmd_valid_i, cmd_op_i, `SBS_OP_ESE_W);

  // event flags
  assign opc_done  = opc_pend_ff && all_done_i;

  // each event source sets its own flag in every cycle it is active, an error only if its code lies in a class; remote/manual only on the rising edge of local_i
  always @* begin
    esr_set = 8'h00;
    if (opc_done) begin
      esr_set[`SBS_EV_OPC] = 1'b1;
    end
    if (query_err_i) begin
      esr_set[`SBS_EV_QYE] = 1'b1;
    end
    if (err_event_i) begin
      esr_set = esr_set | err_class(err_code_i);
    end
    if (local_i && !local_prev_ff) begin
      esr_set[`SBS_EV_URQ] = 1'b1;
    end
  end

  assign esr_clear = cmd_hit(cmd_valid_i, cmd_op_i, `SBS_OP_ESR_Q)
                   || cmd_hit(cmd_valid_i, cmd_op_i, `SBS_OP_CLS);

  sbs_event_flags #(
    .WIDTH (8)
  ) u_flags (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .set_i     (esr_set),
    .clear_i   (esr_clear),
    .flags_o   (standard_event_flags)
  );

  // summary of enabled flags; any set flag whose enable is set raises it
  assign esb = |(standard_event_flags & ese_ff);

  // status byte without its summary bit; bits 0 and 1 stay zero
  always @* begin
    stb_low                = 8'h00;
    stb_low[`SBS_STB_ERRQ] = err_queue_nonempty_i;
    stb_low[`SBS_STB_QUES] = ques_summary_i;
    stb_low[`SBS_STB_MAV]  = mav_i;
    stb_low[`SBS_STB_ESB]  = esb;
    stb_low[`SBS_STB_OPER] = oper_summary_i;
  end

  // enable bit 6 never takes part in the request
  assign sre_eff = sre_ff & ~bit_at(`SBS_STB_MSS);
  assign req_now = stb_low & sre_eff;
  assign mss     = |req_now;
  assign stb     = stb_low | (mss ? bit_at(`SBS_STB_MSS) : 8'h00);

  // every bit including 6 counts for the poll flag
  assign ist = |(stb & ppe_ff);

  // edge per bit, plus every new error entry while its enable is set
  assign srq_event = (|(req_now & ~req_prev_ff))
                   || (err_event_i && sre_eff[`SBS_STB_ERRQ]);

  // enable masks, written by their set commands
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sre_ff <= `SBS_SRE_RST;
      ppe_ff <= `SBS_PPE_RST;
      ese_ff <= `SBS_ESE_RST;
    end else begin
      if (is_write) begin
        case (cmd_op_i)
          `SBS_OP_SRE_W: begin
            sre_ff <= cmd_data_i;
          end
          `SBS_OP_PRE_W: begin
            ppe_ff <= cmd_data_i;
          end
          `SBS_OP_ESE_W: begin
            ese_ff <= cmd_data_i;
          end
          default: begin
            sre_ff <= sre_ff;
          end
        endcase
      end
    end
  end

  // request edge history, sticky request and registered poll flag
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_prev_ff <= 8'h00;
      rqs_ff      <= 1'b0;
      ist_ff      <= 1'b0;
    end else begin
      req_prev_ff <= req_now;
      // a new request in the poll cycle is kept
      rqs_ff      <= srq_event | (rqs_ff & ~spoll_i);
      ist_ff      <= ist;
    end
  end

  // pending operation-complete and remote/manual history
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      opc_pend_ff   <= 1'b0;
      local_prev_ff <= 1'b0;
    end else begin
      if (cmd_hit(cmd_valid_i, cmd_op_i, `SBS_OP_OPC)) begin
        opc_pend_ff <= 1'b1;
      end else if (opc_done) begin
        opc_pend_ff <= 1'b0;
      end
      local_prev_ff <= local_i;
    end
  end

  // command answers, one cycle after the command
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= 8'h00;
    end else begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= 8'h00;
      if (cmd_valid_i) begin
        case (cmd_op_i)
          `SBS_OP_STB_Q: begin
            rsp_valid_ff <= 1'b1;
            rsp_data_ff  <= stb;
          end
          `SBS_OP_SRE_Q: begin
            rsp_valid_ff <= 1'b1;
            rsp_data_ff  <= sre_ff;
          end
          `SBS_OP_PRE_Q: begin
            rsp_valid_ff <= 1'b1;
            rsp_data_ff  <= ppe_ff;
          end
          `SBS_OP_ESE_Q: begin
            rsp_valid_ff <= 1'b1;
            rsp_data_ff  <= ese_ff;
          end
          `SBS_OP_ESR_Q: begin
            rsp_valid_ff <= 1'b1;
            rsp_data_ff  <= standard_event_flags;
          end
          `SBS_OP_IST_Q: begin
            rsp_valid_ff <= 1'b1;
            rsp_data_ff  <= {7'h00, ist};
          end
          default: begin
            rsp_valid_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // serial poll answer and forwarding of error codes to the queue
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      spoll_valid_ff <= 1'b0;
      spoll_data_ff  <= 8'h00;
      err_enq_ff     <= 1'b0;
      err_code_ff    <= 16'h0000;
    end else begin
      spoll_valid_ff <= spoll_i;
      spoll_data_ff  <= spoll_i ? stb : 8'h00;
      err_enq_ff     <= err_event_i;
      if (err_event_i) begin
        err_code_ff  <= err_code_i;
      end
    end
  end

  assign rsp_valid_o   = rsp_valid_ff;
  assign rsp_data_o    = rsp_data_ff;
  assign spoll_valid_o = spoll_valid_ff;
  assign spoll_data_o  = spoll_data_ff;
  assign ist_o         = ist_ff;
  assign srq_o         = rqs_ff;
  assign err_enq_o     = err_enq_ff;
  assign err_code_o    = err_code_ff;

endmodule // sbs_status_byte

//--- sim/sbs_chk_checker.sv
// port assertions for the status byte block
`timescale 1ns/1ns
`include "sbs_defs.vh"
module sbs_chk (
  input wire               clk_sys_i,
  input wire               arst_n_i,
  input wire               cmd_valid_i,
  input wire               spoll_i,
  input wire               err_event_i,
  input wire               rsp_valid_o,
  input wire               spoll_valid_o,
  input wire               srq_o,
  input wire               err_enq_o,
  input wire [3:0]         cmd_op_i,
  input wire [7:0]         rsp_data_o,
  input wire [7:0]         spoll_data_o,
  input wire signed [15:0] err_code_i,
  input wire [15:0]        err_code_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_status_query_answer: assert property (cmd_valid_i && cmd_op_i == `SBS_OP_STB_Q |=> rsp_valid_o)
    else $error("status query not answered");
  a_mask_write_silent: assert property (cmd_valid_i && cmd_op_i == `SBS_OP_SRE_W |=> !rsp_valid_o)
    else $error("mask write answered");
  a_poll_answer: assert property (spoll_i |=> spoll_valid_o)
    else $error("serial poll not answered");
  a_unused_bits_zero: assert property (spoll_valid_o |-> spoll_data_o[1:0] == 2'b00)
    else $error("unused status bits set");
  a_request_held: assert property (srq_o && !spoll_i |=> srq_o)
    else $error("service request dropped without poll");
  a_error_enqueued: assert property (err_event_i |=> err_enq_o && err_code_o == $past(err_code_i))
    else $error("error code not enqueued");
  a_enqueue_cause: assert property (err_enq_o |-> $past(err_event_i))
    else $error("enqueue without error");
  a_poll_flag_byte: assert property (cmd_valid_i && cmd_op_i == `SBS_OP_IST_Q |=> rsp_data_o[7:1] == 7'h00)
    else $error("poll flag answer not one bit");
  a_answer_idle_zero: assert property (!rsp_valid_o |-> rsp_data_o == 8'h00)
    else $error("answer data without strobe");
endmodule // sbs_chk
bind sbs_status_byte sbs_chk u_chk (.*);

//--- sim/sbs_ctrl_model.sv
// remote controller model on the command and serial poll ports
`timescale 1ns/1ns
module sbs_ctrl_model (
  input  wire       clk_sys_i,
  input  wire [7:0] rsp_data_i,
  input  wire [7:0] spoll_data_i,
  output reg        cmd_valid_o = 1'b0,
  output reg  [3:0] cmd_op_o = 4'h0,
  output reg  [7:0] cmd_data_o = 8'h00,
  output reg        spoll_o = 1'b0
);
  task xfer(input [3:0] op, input [7:0] d, output [7:0] r);
    begin
      @(posedge clk_sys_i);
      cmd_valid_o <= 1'b1;
      cmd_op_o <= op;
      cmd_data_o <= d;
      @(posedge clk_sys_i);
      cmd_valid_o <= 1'b0;
      // released data flips so a stale byte is never mistaken for valid
      cmd_data_o <= ~d;
      @(posedge clk_sys_i);
      r = rsp_data_i;
    end
  endtask
  task poll(output [7:0] r);
    begin
      @(posedge clk_sys_i);
      spoll_o <= 1'b1;
      @(posedge clk_sys_i);
      spoll_o <= 1'b0;
      @(posedge clk_sys_i);
      r = spoll_data_i;
    end
  endtask
endmodule // sbs_ctrl_model

//--- sim/status_byte_service_request_tb_top.sv
// self-checking bench for the status byte block
`timescale 1ns/1ns
`include "sbs_defs.vh"
module status_byte_service_request_tb_top;
  reg  clk_sys_i = 1'b0, arst_n_i = 1'b0, err_event_i = 1'b0, err_queue_nonempty_i = 1'b0;
  reg  ques_summary_i = 1'b0, oper_summary_i = 1'b0, mav_i = 1'b0, all_done_i = 1'b1;
  reg  query_err_i = 1'b0, local_i = 1'b0;
  reg  signed [15:0] err_code_i = 16'sh0000;
  wire cmd_valid_i, spoll_i, rsp_valid_o, spoll_valid_o, ist_o, srq_o, err_enq_o;
  wire [3:0] cmd_op_i;
  wire [7:0] cmd_data_i, rsp_data_o, spoll_data_o;
  wire [15:0] err_code_o;
  integer fails = 0, total_checks = 0, cyc = 0, i;
  reg [7:0] r;
  reg [23:0] masks = 24'h204010;
  reg [111:0] codes = 112'hFFCE0005FED4FEA2FF38FF06FF6A;
  reg [55:0] exps = 56'h00080808101020;
  sbs_status_byte dut (.*);
  sbs_ctrl_model u_ctrl (.clk_sys_i(clk_sys_i), .rsp_data_i(rsp_data_o),
    .spoll_data_i(spoll_data_o), .cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i),
    .cmd_data_o(cmd_data_i), .spoll_o(spoll_i));
  always #4 clk_sys_i = ~clk_sys_i;
  task summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task q(input [3:0] op, input [7:0] e, input [63:0] nm);
    begin
      u_ctrl.xfer(op, 8'h00, r);
      chk(nm, e, r);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task err(input [15:0] c);
    begin
      @(posedge clk_sys_i);
      err_event_i <= 1'b1;
      err_code_i <= c;
      @(posedge clk_sys_i);
      err_event_i <= 1'b0;
    end
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      summarize;
    end
  end
  initial begin
    tick(16);
    arst_n_i <= 1'b1;
    q(`SBS_OP_ESR_Q, 8'h80, "esr_pon");
    q(`SBS_OP_ESR_Q, 8'h00, "esr_rd");
    for (i = 0; i < 3; i = i + 1) begin
      q(4'h3 + {i[2:0], 1'b0}, 8'h00, "mask_rst");
      u_ctrl.xfer(4'h2 + {i[2:0], 1'b0}, masks[8*i+:8], r);
      q(4'h3 + {i[2:0], 1'b0}, masks[8*i+:8], "mask_rb");
    end
    mav_i <= 1'b1;
    tick(3);
    chk("srq_mav", 8'h01, {7'h00, srq_o});
    chk("ist_mss", 8'h01, {7'h00, ist_o});
    q(`SBS_OP_IST_Q, 8'h01, "ist_q");
    q(`SBS_OP_STB_Q, 8'h50, "stb_q");
    u_ctrl.poll(r);
    chk("spoll", 8'h50, r);
    chk("srq_pol", 8'h00, {7'h00, srq_o});
    mav_i <= 1'b0;
    err_queue_nonempty_i <= 1'b1;
    ques_summary_i <= 1'b1;
    oper_summary_i <= 1'b1;
    q(`SBS_OP_STB_Q, 8'h8C, "stb_sum");
    chk("srq_off", 8'h00, {7'h00, srq_o});
    u_ctrl.xfer(`SBS_OP_SRE_W, 8'h44, r);
    // enabling bit 2 raised a request; poll it away so the error path stands alone
    u_ctrl.poll(r);
    chk("spoll_cc", 8'hCC, r);
    chk("srq_clr", 8'h00, {7'h00, srq_o});
    for (i = 0; i < 7; i = i + 1) begin
      err(codes[16*i+:16]);
      if (i == 0) begin
        tick(2);
        chk("srq_err", 8'h01, {7'h00, srq_o});
        q(`SBS_OP_STB_Q, 8'hEC, "stb_esb");
      end
      q(`SBS_OP_ESR_Q, exps[8*i+:8], "esr_err");
    end
    query_err_i <= 1'b1;
    tick(1);
    query_err_i <= 1'b0;
    q(`SBS_OP_ESR_Q, 8'h04, "esr_qye");
    local_i <= 1'b1;
    tick(2);
    q(`SBS_OP_ESR_Q, 8'h40, "esr_urq");
    all_done_i <= 1'b0;
    u_ctrl.xfer(`SBS_OP_OPC, 8'h00, r);
    q(`SBS_OP_ESR_Q, 8'h00, "esr_busy");
    all_done_i <= 1'b1;
    tick(2);
    q(`SBS_OP_ESR_Q, 8'h01, "esr_opc");
    query_err_i <= 1'b1;
    tick(1);
    query_err_i <= 1'b0;
    u_ctrl.xfer(`SBS_OP_CLS, 8'h00, r);
    q(`SBS_OP_ESR_Q, 8'h00, "esr_cls");
    summarize;
  end
endmodule // status_byte_service_request_tb_top
